// ===== exception_syndrome_access.sv
// access control and syndrome capture for level-1 and level-2 syndromes
`timescale 1ns/1ps
`default_nettype none
`include "syndrome_defs.svh"

// Summary of operation
// - syndrome bit0 marks A or B key
// - key bit not relied on after reset
// - pure authenticate failure always raises exception
// - combined instructions: caller chooses exception or corruption
// - alias ordering from top level needs sync
// - decode level-1 name at its encoding
// - decode alias op1=5, level-2 op1=4
// - lowest level access is undefined
// - vm read/write trap bits trap to level2
// - fine grained trap bits trap to level2
// - nested 111 redirects to deferred page 0x138
// - level-1 name access from level2 follows host extension
// - alias reach, redirect, trap or undefined
// - level-2 name from level1: reach, trap, undefined
// - 64-bit level2 reg, zero if absent
// - level2 value undefined after return
// - undefined syndrome matches legitimate exception
// - top byte zero, bits 55:32 extra field
// - data abort extra field holds status index
// - instruction abort extra field zero
// - syndrome bit1 marks instruction or data key
// - bits 31:26 hold exception class
module exception_syndrome_access
(
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst,
    // pipeline requests and controls
    input  wire syndrome_pkg::sysreg_req_type  req,
    input  wire syndrome_pkg::hyp_ctrl_type    ctrl,
    input  wire syndrome_pkg::exc_type         exc,
    // access answer
    output logic                               resp_valid_q,
    output syndrome_pkg::result_type           resp_result_q,
    output logic [63:0]                        resp_rdata_q,
    // deferred page read/write request port
    output logic                               defer_we_q,
    output logic                               defer_re_q,
    output logic [11:0]                        defer_offset_q,
    output logic [63:0]                        defer_wdata_q,
    // trap exception to level2
    output logic                               trap_valid_q,
    output logic [5:0]                         trap_ec_q,
    // stored syndromes
    output logic [63:0]                        level1_syndrome_q,
    output logic [63:0]                        level2_syndrome_q
);

    // -----------------------------------------------------------------
    // decode functions
    // -----------------------------------------------------------------
    // common encoding match for a given op1
    function automatic logic enc_match(input syndrome_pkg::sysreg_req_type r,
                                       input logic [2:0] op1);
        enc_match = r.op0 == `SYN_OP0 && r.op1 == op1 && r.crn == `SYN_CRN &&
                    r.crm == `SYN_CRM && r.op2 == `SYN_OP2;
    endfunction : enc_match
    // build a stored syndrome with extra field cleaned per class
    function automatic logic [63:0] build_syn(input syndrome_pkg::exc_type e);
        logic [23:0] x2;
        logic [24:0] iss;
        x2  = 24'h000000;
        iss = e.iss;
        if ((e.ec == `SYN_EC_DABT_LO || e.ec == `SYN_EC_DABT_SM) && e.store64_fault)
            x2[4:0] = e.store_status_reg_index;
        // instruction aborts leave the extra field all zero
        if (e.auth_fail)
        begin
            iss = 25'h0;
            iss[`SYN_KEYB_BIT] = e.auth_b_key;
            iss[`SYN_KEYD_BIT] = e.auth_data_key;
        end
        build_syn = {8'h00, x2, e.ec, 1'b1, iss};
    endfunction : build_syn

    // -----------------------------------------------------------------
    // access resolution
    // -----------------------------------------------------------------
    logic        hit_l1;    // level-1 name
    logic        hit_alias; // alias name
    logic        hit_l2;    // level-2 name
    logic        l2on;      // level 2 enabled
    logic        fine_ok;   // fine traps active
    logic [2:0]  nvc;       // defer, level1, nested bits
    syndrome_pkg::result_type res_d;
    logic        tgt_l1_d;  // access reaches level-1 register
    logic        tgt_l2_d;  // access reaches level-2 register
    logic        zero_d;    // level2 absent: reads zero
    assign hit_l1    = enc_match(req, `SYN_OP1_L1);
    assign hit_alias = enc_match(req, `SYN_OP1_ALIAS);
    assign hit_l2    = enc_match(req, `SYN_OP1_L2);
    assign l2on      = ctrl.l2_enabled;
    assign fine_ok   = l2on && ctrl.fine_traps_impl &&
                       (!ctrl.l3_implemented || ctrl.fine_trap_gate);
    assign nvc       = {ctrl.nested_virt_defer_bit, ctrl.nested_virt_level1_bit,
                        ctrl.nested_virt_bit};
    // priority walk mirroring the per-level access tables
    always_comb
    begin
        res_d    = syndrome_pkg::RES_NONE;
        tgt_l1_d = 1'b0;
        tgt_l2_d = 1'b0;
        zero_d   = 1'b0;
        if (req.valid && (hit_l1 || hit_alias || hit_l2))
        begin
            res_d = syndrome_pkg::RES_DONE;
            unique case (req.level)
                syndrome_pkg::LVL0:
                    res_d = syndrome_pkg::RES_UNDEF;
                syndrome_pkg::LVL1:
                begin
                    if (hit_l1)
                    begin
                        if (l2on && (req.write ? ctrl.trap_write_vm_regs
                                               : ctrl.trap_read_vm_regs))
                            res_d = syndrome_pkg::RES_TRAP;
                        else if (fine_ok && (req.write ? ctrl.fine_write_trap
                                                       : ctrl.fine_read_trap))
                            res_d = syndrome_pkg::RES_TRAP;
                        else if (l2on && nvc == 3'b111)
                            res_d = syndrome_pkg::RES_DEFER;
                        else
                            tgt_l1_d = 1'b1;
                    end
                    else if (hit_alias)
                    begin
                        if (l2on && nvc == 3'b101)
                            res_d = syndrome_pkg::RES_DEFER;
                        else if (l2on && ctrl.nested_virt_bit)
                            res_d = syndrome_pkg::RES_TRAP;
                        else
                            res_d = syndrome_pkg::RES_UNDEF;
                    end
                    else if (l2on && ctrl.nested_virt_defer_bit && ctrl.nested_virt_bit)
                        tgt_l1_d = 1'b1;
                    else if (l2on && ctrl.nested_virt_bit)
                        res_d = syndrome_pkg::RES_TRAP;
                    else
                        res_d = syndrome_pkg::RES_UNDEF;
                end
                syndrome_pkg::LVL2:
                begin
                    if (hit_l1)
                    begin
                        tgt_l2_d = ctrl.host_extension_enable;
                        tgt_l1_d = !ctrl.host_extension_enable;
                    end
                    else if (hit_alias)
                    begin
                        if (ctrl.host_extension_enable)
                            tgt_l1_d = 1'b1;
                        else
                            res_d = syndrome_pkg::RES_UNDEF;
                    end
                    else
                        tgt_l2_d = 1'b1;
                end
                syndrome_pkg::LVL3:
                begin
                    // no ordering between the two names here; software syncs
                    if (hit_l1)
                        tgt_l1_d = 1'b1;
                    else if (hit_alias)
                    begin
                        if (l2on && ctrl.host_extension_enable)
                            tgt_l1_d = 1'b1;
                        else
                            res_d = syndrome_pkg::RES_UNDEF;
                    end
                    else if (ctrl.l2_implemented)
                        tgt_l2_d = 1'b1;
                    else
                        zero_d = 1'b1;
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // syndrome storage
    // -----------------------------------------------------------------
    logic        l1_we;   // level-1 write strobe
    logic        l2_we;   // level-2 write strobe
    logic [63:0] l1_wd;   // level-1 write data
    logic [63:0] l2_wd;   // level-2 write data
    logic        acc_wr;  // register write that lands
    logic        trap_go; // trap or undefined into level2
    logic [63:0] trap_syn;
    assign acc_wr  = req.write && res_d == syndrome_pkg::RES_DONE;
    // undefined from level1+ routed here with the unknown class, a value
    // any legitimate undefined could leave, so nothing leaks upward
    assign trap_go = res_d == syndrome_pkg::RES_TRAP ||
                     (res_d == syndrome_pkg::RES_UNDEF && req.level != syndrome_pkg::LVL0 &&
                      l2on);
    assign trap_syn = {8'h00, 24'h000000,
                       (res_d == syndrome_pkg::RES_TRAP) ? `SYN_EC_SYSREG : `SYN_EC_UNKNOWN,
                       1'b1, 25'h0};
    // exception commit wins over an access in the same cycle; a trapped
    // access touches only the level-2 syndrome
    always_comb
    begin
        l1_we = 1'b0;
        l2_we = 1'b0;
        l1_wd = req.wdata;
        l2_wd = req.wdata;
        if (exc.valid)
        begin
            l1_we = !exc.to_level2;
            l2_we = exc.to_level2;
            l1_wd = build_syn(exc);
            l2_wd = build_syn(exc);
        end
        else if (trap_go)
        begin
            l2_we = ctrl.l2_implemented;
            l2_wd = trap_syn;
        end
        else if (acc_wr)
        begin
            l1_we = tgt_l1_d;
            l2_we = tgt_l2_d && ctrl.l2_implemented;
        end
    end
    // level-1 syndrome word; not reset-relied upon by software
    syndrome_store u_l1
    (
        .clk(clk), .rst(rst), .we(l1_we), .wdata(l1_wd), .value_q(level1_syndrome_q)
    );
    // level-2 syndrome word, kept across returns as an allowed value
    syndrome_store u_l2
    (
        .clk(clk), .rst(rst), .we(l2_we), .wdata(l2_wd), .value_q(level2_syndrome_q)
    );

    // -----------------------------------------------------------------
    // answer registers
    // -----------------------------------------------------------------
    // one-cycle answer to each access
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            resp_valid_q  <= 1'b0;
            resp_result_q <= syndrome_pkg::RES_NONE;
            resp_rdata_q  <= 64'h0;
        end
        else
        begin
            resp_valid_q  <= res_d != syndrome_pkg::RES_NONE;
            resp_result_q <= res_d;
            if (res_d == syndrome_pkg::RES_DONE && !req.write)
                resp_rdata_q <= zero_d   ? 64'h0 :
                                tgt_l2_d ? level2_syndrome_q : level1_syndrome_q;
            else
                resp_rdata_q <= 64'h0;
        end
    end
    // deferred page request
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            defer_we_q     <= 1'b0;
            defer_re_q     <= 1'b0;
            defer_offset_q <= 12'h000;
            defer_wdata_q  <= 64'h0;
        end
        else
        begin
            defer_we_q     <= res_d == syndrome_pkg::RES_DEFER && req.write;
            defer_re_q     <= res_d == syndrome_pkg::RES_DEFER && !req.write;
            defer_offset_q <= `SYN_DEFER_OFS;
            defer_wdata_q  <= req.wdata;
        end
    end
    // trap notification
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            trap_valid_q <= 1'b0;
            trap_ec_q    <= 6'h00;
        end
        else
        begin
            trap_valid_q <= res_d == syndrome_pkg::RES_TRAP;
            trap_ec_q    <= (res_d == syndrome_pkg::RES_TRAP) ? `SYN_EC_SYSREG : 6'h00;
        end
    end

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    undef_low_a: assert property (@(posedge clk) disable iff (rst)
        req.valid && hit_l1 && req.level == syndrome_pkg::LVL0
        |=> resp_result_q == syndrome_pkg::RES_UNDEF)
        else $error("lowest level access not undefined");
    vm_trap_a: assert property (@(posedge clk) disable iff (rst)
        req.valid && hit_l1 && req.level == syndrome_pkg::LVL1 && l2on && !req.write &&
        ctrl.trap_read_vm_regs |=> trap_valid_q && trap_ec_q == 6'h18)
        else $error("vm read trap missing");
    defer_redir_a: assert property (@(posedge clk) disable iff (rst)
        res_d == syndrome_pkg::RES_DEFER |=> (defer_we_q || defer_re_q) &&
        defer_offset_q == 12'h138)
        else $error("deferred access not issued");
    top_zero_a: assert property (@(posedge clk) disable iff (rst)
        level2_syndrome_q[63:56] == 8'h00 && level1_syndrome_q[63:56] == 8'h00)
        else $error("reserved byte not zero");
    commit_upd_a: assert property (@(posedge clk) disable iff (rst)
        exc.valid && exc.to_level2 |=> level2_syndrome_q[31:26] == $past(exc.ec))
        else $error("syndrome not updated on commit");
    trap_keep_a: assert property (@(posedge clk) disable iff (rst)
        !exc.valid && res_d == syndrome_pkg::RES_TRAP |=> $stable(level1_syndrome_q))
        else $error("trap changed level1 syndrome");
    alias_undef_a: assert property (@(posedge clk) disable iff (rst)
        req.valid && hit_alias && req.level == syndrome_pkg::LVL2 &&
        !ctrl.host_extension_enable |=> resp_result_q == syndrome_pkg::RES_UNDEF)
        else $error("alias without host extension not undefined");
    key_bit_a: assert property (@(posedge clk) disable iff (rst)
        exc.valid && !exc.to_level2 && exc.auth_fail
        |=> level1_syndrome_q[0] == $past(exc.auth_b_key) &&
            level1_syndrome_q[1] == $past(exc.auth_data_key))
        else $error("key select bits wrong");
    cv_defer_c: cover property (@(posedge clk) defer_we_q);
    cv_trap_c: cover property (@(posedge clk) trap_valid_q);
    cv_alias_c: cover property (@(posedge clk) req.valid && hit_alias && tgt_l1_d);
endmodule : exception_syndrome_access

`default_nettype wire

// ===== pipeline_model.sv
// pipeline model issuing syndrome register accesses and exception commits
`timescale 1ns/1ps
`default_nettype none

module pipeline_model
(
    // clock
    input  wire logic                        clk,
    // issue side
    output var syndrome_pkg::sysreg_req_type req,
    output var syndrome_pkg::exc_type        exc
);
    // -----------------------------------------------------------------
    // issue tasks
    // -----------------------------------------------------------------
    // idle at time zero
    initial
    begin
        req = '0;
        exc = '0;
    end

    // one access held for a single edge; two idle cycles first keep
    // alias and level-1 name accesses apart, as a sync would
    task automatic access(input logic wr, input syndrome_pkg::level_type lv,
                          input logic [2:0] op1, input logic [63:0] wd);
        @(negedge clk);
        @(negedge clk);
        req = '{1'b1, wr, lv, 2'h3, op1, 4'h5, 4'h2, 3'h0, wd};
        @(negedge clk);
        // released data shows the inverse, never the stale word
        req = '{1'b0, 1'b0, syndrome_pkg::LVL0, 2'h0, 3'h0, 4'h0, 4'h0, 3'h0, ~wd};
    endtask : access

    // one exception commit pulse
    task automatic commit(input syndrome_pkg::exc_type e);
        @(negedge clk);
        exc = e;
        @(negedge clk);
        exc = '0;
    endtask : commit
endmodule : pipeline_model
`default_nettype wire

// ===== syndrome_defs.svh
// constants for the exception syndrome access block
`ifndef SYNDROME_DEFS_SVH
`define SYNDROME_DEFS_SVH

// -----------------------------------------------------------------
// system register encodings
// -----------------------------------------------------------------
`define SYN_OP0        2'h3
`define SYN_CRN        4'h5
`define SYN_CRM        4'h2
`define SYN_OP2        3'h0
`define SYN_OP1_L1     3'h0
`define SYN_OP1_ALIAS  3'h5
`define SYN_OP1_L2     3'h4

// -----------------------------------------------------------------
// classes, offsets and field positions
// -----------------------------------------------------------------
`define SYN_EC_SYSREG  6'h18
`define SYN_EC_UNKNOWN 6'h00
`define SYN_EC_DABT_LO 6'h24
`define SYN_EC_DABT_SM 6'h25
`define SYN_EC_IABT_LO 6'h20
`define SYN_EC_IABT_SM 6'h21
`define SYN_DEFER_OFS  12'h138
`define SYN_EC_MSB     31
`define SYN_EC_LSB     26
`define SYN_X2_MSB     55
`define SYN_X2_LSB     32
`define SYN_RES_MSB    63
`define SYN_RES_LSB    56
`define SYN_KEYB_BIT   0
`define SYN_KEYD_BIT   1
`define SYN_RESET_VAL  64'h0

`endif

// ===== syndrome_pkg.sv
// types shared by the exception syndrome access block
package syndrome_pkg;

    // privilege level of the issuing instruction
    typedef enum logic [1:0]
    {
        LVL0 = 2'b00,
        LVL1 = 2'b01,
        LVL2 = 2'b10,
        LVL3 = 2'b11
    } level_type;

    // system register access request
    typedef struct packed
    {
        logic        valid;
        logic        write;
        level_type   level;
        logic [1:0]  op0;
        logic [2:0]  op1;
        logic [3:0]  crn;
        logic [3:0]  crm;
        logic [2:0]  op2;
        logic [63:0] wdata;
    } sysreg_req_type;

    // hypervisor controls seen by the block
    typedef struct packed
    {
        logic l2_implemented;
        logic l2_enabled;
        logic l3_implemented;
        logic fine_traps_impl;
        logic fine_trap_gate;
        logic fine_read_trap;
        logic fine_write_trap;
        logic host_extension_enable;
        logic trap_read_vm_regs;
        logic trap_write_vm_regs;
        logic nested_virt_bit;
        logic nested_virt_level1_bit;
        logic nested_virt_defer_bit;
    } hyp_ctrl_type;

    // exception being committed
    typedef struct packed
    {
        logic        valid;
        logic        to_level2;
        logic [5:0]  ec;
        logic [24:0] iss;
        logic        store64_fault;
        logic [4:0]  store_status_reg_index;
        logic        auth_fail;
        logic        auth_data_key;
        logic        auth_b_key;
    } exc_type;

    // outcome of an access
    typedef enum logic [2:0]
    {
        RES_NONE  = 3'b000,
        RES_DONE  = 3'b001,
        RES_TRAP  = 3'b010,
        RES_UNDEF = 3'b011,
        RES_DEFER = 3'b100
    } result_type;

endpackage : syndrome_pkg

// ===== syndrome_store.sv
// one 64-bit syndrome word with registered read port
`timescale 1ns/1ps
`default_nettype none
`include "syndrome_defs.svh"

module syndrome_store
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // write side
    input  wire logic        we,
    input  wire logic [63:0] wdata,
    // registered contents
    output logic      [63:0] value_q
);

    // -----------------------------------------------------------------
    // storage
    // -----------------------------------------------------------------
    // top byte is forced to zero on every write so it always reads zero
    always_ff @(posedge clk)
    begin
        if (rst)
            value_q <= `SYN_RESET_VAL;
        else if (we)
            value_q <= {8'h00, wdata[55:0]};
    end

endmodule : syndrome_store

`default_nettype wire

// ===== test_exception_syndrome_access.sv
// self-checking testbench for the exception syndrome access block
`timescale 1ns/1ps
`default_nettype none
`include "syndrome_defs.svh"

// compare, count and report one value
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end

module test_exception_syndrome_access;
    // -----------------------------------------------------------------
    // signals
    // -----------------------------------------------------------------
    logic                         clk;         // core clock
    logic                         rst;         // sync reset
    syndrome_pkg::sysreg_req_type req;         // from the model
    syndrome_pkg::exc_type        exc;         // commits from the model
    syndrome_pkg::hyp_ctrl_type   ctrl;        // hypervisor controls
    logic                         rv;          // answer pulse
    syndrome_pkg::result_type     rres;        // answer kind
    logic [63:0]                  rdat;        // read data
    logic                         dwe;         // deferred write
    logic                         dre;         // deferred read
    logic [11:0]                  dofs;        // deferred offset
    logic [63:0]                  dwd;         // deferred data
    logic                         tv;          // trap pulse
    logic [5:0]                   tec;         // trap class
    logic [63:0]                  syn1;        // level-1 syndrome
    logic [63:0]                  syn2;        // level-2 syndrome
    int                           fail_count;  // mismatches
    int                           checks_done; // comparisons
    localparam logic [5:0]        auth_ec = 6'h1c; // class value is arbitrary

    // -----------------------------------------------------------------
    // clock, parts
    // -----------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    pipeline_model pipe_u (.clk(clk), .req(req), .exc(exc));

    exception_syndrome_access dut_u
    (
        .clk(clk), .rst(rst), .req(req), .ctrl(ctrl), .exc(exc),
        .resp_valid_q(rv), .resp_result_q(rres), .resp_rdata_q(rdat),
        .defer_we_q(dwe), .defer_re_q(dre), .defer_offset_q(dofs), .defer_wdata_q(dwd),
        .trap_valid_q(tv), .trap_ec_q(tec),
        .level1_syndrome_q(syn1), .level2_syndrome_q(syn2)
    );

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    // level 2 and level 3 present and enabled, no traps
    function automatic syndrome_pkg::hyp_ctrl_type base();
        base = '0;
        base.l2_implemented = 1'b1;
        base.l2_enabled     = 1'b1;
        base.l3_implemented = 1'b1;
    endfunction : base

    task automatic expect_resp(input syndrome_pkg::result_type r, input logic [63:0] d);
        `CHK(rv, 1'b1)
        `CHK(rres, r)
        `CHK(rdat, d)
    endtask : expect_resp

    // commit one exception and check the stored word
    task automatic exc_case(input logic l2, input logic [5:0] ec, input logic s64,
                            input logic au, input logic [1:0] key, input logic [23:0] x2);
        logic [63:0] want;
        want = {8'h0, x2, ec, 1'b1, au ? {23'h0, key} : 25'h0a5a5a5};
        pipe_u.commit('{1'b1, l2, ec, 25'h0a5a5a5, s64, 5'h13, au, key[1], key[0]});
        `CHK(l2 ? syn2 : syn1, want)
    endtask : exc_case

    // -----------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------
    // level-2 register: top byte dropped, absent level 2 reads zero
    task automatic t_level2();
        ctrl = base();
        pipe_u.access(1'b1, syndrome_pkg::LVL2, 3'h4, 64'hffee_dd00_1234_5678);
        `CHK(syn2, 64'h00ee_dd00_1234_5678)
        pipe_u.access(1'b0, syndrome_pkg::LVL3, 3'h4, 64'h0);
        expect_resp(syndrome_pkg::RES_DONE, 64'h00ee_dd00_1234_5678);
        ctrl = '0;
        pipe_u.access(1'b1, syndrome_pkg::LVL3, 3'h4, 64'h1);
        pipe_u.access(1'b0, syndrome_pkg::LVL3, 3'h4, 64'h0);
        `CHK(rdat, 64'h0)
    endtask : t_level2

    // which register the level-1 and alias names reach from levels 2 and 3
    task automatic t_names();
        ctrl = base();
        ctrl.host_extension_enable = 1'b1;
        pipe_u.access(1'b1, syndrome_pkg::LVL2, 3'h0, 64'h11);
        `CHK(syn2, 64'h11)
        pipe_u.access(1'b1, syndrome_pkg::LVL3, 3'h0, 64'h22);
        `CHK(syn1, 64'h22)
        pipe_u.access(1'b1, syndrome_pkg::LVL2, 3'h5, 64'h33);
        `CHK(syn1, 64'h33)
        ctrl.host_extension_enable = 1'b0;
        pipe_u.access(1'b1, syndrome_pkg::LVL2, 3'h0, 64'h44);
        `CHK(syn1, 64'h44)
        pipe_u.access(1'b0, syndrome_pkg::LVL3, 3'h5, 64'h0);
        expect_resp(syndrome_pkg::RES_UNDEF, 64'h0);
    endtask : t_names

    // lowest level refused on every name; foreign encoding ignored
    task automatic t_undef();
        logic [2:0] op1s [3];
        op1s = '{3'h0, 3'h5, 3'h4};
        for (int i = 0; i < 3; i++)
        begin
            pipe_u.access(1'b0, syndrome_pkg::LVL0, op1s[i], 64'h0);
            expect_resp(syndrome_pkg::RES_UNDEF, 64'h0);
        end
        pipe_u.access(1'b1, syndrome_pkg::LVL2, 3'h1, 64'h0);
        `CHK(rv, 1'b0)
    endtask : t_undef

    // traps to level 2 leave the target alone
    task automatic t_traps();
        ctrl = base();
        ctrl.trap_read_vm_regs = 1'b1;
        pipe_u.access(1'b0, syndrome_pkg::LVL1, 3'h0, 64'h0);
        expect_resp(syndrome_pkg::RES_TRAP, 64'h0);
        `CHK({tv, tec, syn2[31:26]}, {1'b1, 6'h18, 6'h18})
        ctrl = base();
        ctrl.trap_write_vm_regs = 1'b1;
        pipe_u.access(1'b1, syndrome_pkg::LVL1, 3'h0, 64'h55);
        `CHK({tv, syn1}, {1'b1, 64'h44})
        ctrl = base();
        ctrl.l3_implemented  = 1'b0;
        ctrl.fine_traps_impl = 1'b1;
        ctrl.fine_write_trap = 1'b1;
        pipe_u.access(1'b1, syndrome_pkg::LVL1, 3'h0, 64'h56);
        `CHK({tv, syn1}, {1'b1, 64'h44})
        {ctrl.l3_implemented, ctrl.fine_trap_gate, ctrl.fine_read_trap} = 3'h7;
        pipe_u.access(1'b0, syndrome_pkg::LVL1, 3'h0, 64'h0);
        `CHK({tv, rres}, {1'b1, syndrome_pkg::RES_TRAP})
        ctrl = base();
        ctrl.nested_virt_bit = 1'b1;
        pipe_u.access(1'b0, syndrome_pkg::LVL1, 3'h4, 64'h0);
        `CHK(tv, 1'b1)
        pipe_u.access(1'b0, syndrome_pkg::LVL1, 3'h5, 64'h0);
        `CHK(tv, 1'b1)
    endtask : t_traps

    // nested controls: deferred page, redirect, undefined
    task automatic t_defer();
        ctrl = base();
        {ctrl.nested_virt_defer_bit, ctrl.nested_virt_level1_bit, ctrl.nested_virt_bit} = 3'h7;
        pipe_u.access(1'b1, syndrome_pkg::LVL1, 3'h0, 64'h66);
        `CHK({rres, dwe, dofs, dwd}, {syndrome_pkg::RES_DEFER, 1'b1, `SYN_DEFER_OFS, 64'h66})
        `CHK(syn1, 64'h44)
        pipe_u.access(1'b0, syndrome_pkg::LVL1, 3'h0, 64'h0);
        `CHK({dre, dofs}, {1'b1, 12'h138})
        ctrl.nested_virt_level1_bit = 1'b0;
        pipe_u.access(1'b0, syndrome_pkg::LVL1, 3'h5, 64'h0);
        `CHK({dre, dofs}, {1'b1, 12'h138})
        pipe_u.access(1'b1, syndrome_pkg::LVL1, 3'h4, 64'h77);
        `CHK(syn1, 64'h77)
        ctrl = base();
        pipe_u.access(1'b0, syndrome_pkg::LVL1, 3'h4, 64'h0);
        expect_resp(syndrome_pkg::RES_UNDEF, 64'h0);
    endtask : t_defer

    // commits: key bits, class field, extra field by class
    task automatic t_exc();
        for (int k = 0; k < 4; k++)
        begin
            exc_case(k[0], auth_ec, 1'b0, 1'b1, k[1:0], 24'h0);
        end
        exc_case(1'b1, 6'h24, 1'b1, 1'b0, 2'h0, 24'h13);
        exc_case(1'b0, 6'h25, 1'b0, 1'b0, 2'h0, 24'h0);
        exc_case(1'b1, 6'h20, 1'b1, 1'b0, 2'h0, 24'h0);
        exc_case(1'b0, 6'h21, 1'b1, 1'b0, 2'h0, 24'h0);
    endtask : t_exc

    // -----------------------------------------------------------------
    // sequence, watchdog, verdict
    // -----------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize

    initial
    begin
        fail_count  = 0;
        checks_done = 0;
        ctrl        = '0;
        rst         = 1'b1;
        repeat (5) @(negedge clk);
        `CHK({rv, syn1, syn2}, 129'h0)
        rst = 1'b0;
        t_level2();
        t_names();
        t_undef();
        t_traps();
        t_defer();
        t_exc();
        summarize();
    end

    // whole run needs well under a microsecond
    initial
    begin
        #5000;
        fail_count++;
        summarize();
    end
endmodule : test_exception_syndrome_access
`default_nettype wire
